// [inc/mmt_pkg.sv]
// Shared constants and types for the min/max tracker
package mmt_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned SEL_W    = DATA_W / 8;
   localparam int unsigned STATUS_W = 2;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_SAMPLE = 8'h04;
   localparam logic [7:0] OFS_MIN    = 8'h08;
   localparam logic [7:0] OFS_MAX    = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK   = 8'h14;
   localparam logic [7:0] OFS_EVALS  = 8'h18;

   // ==========================================================
   // Control register fields
   localparam int unsigned CTRL_ENABLE_BIT  = 0;
   localparam int unsigned CTRL_MODE_BIT    = 1;
   localparam int unsigned CTRL_CLEAR_BIT   = 2;
   localparam int unsigned CTRL_TRIGGER_BIT = 3;
   localparam int unsigned CTRL_W           = 4;

   // ==========================================================
   // Status and mask fields
   localparam int unsigned STAT_NEW_MIN_BIT = 0;
   localparam int unsigned STAT_NEW_MAX_BIT = 1;

   // ==========================================================
   // Reset values
   localparam logic [CTRL_W-1:0]   CTRL_RESET   = 4'h0;
   localparam logic [DATA_W-1:0]   DATA_RESET   = 32'h0000_0000;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 2'h0;
   localparam logic [STATUS_W-1:0] MASK_RESET   = 2'h0;
   localparam logic [DATA_W-1:0]   EXTREME_ZERO = 32'h0000_0000;
   localparam logic [DATA_W-1:0]   EVALS_ONE    = 32'h0000_0001;

   // ==========================================================
   // Trigger mode encoding
   typedef enum logic
   {
      MMT_MODE_CYCLIC = 1'b0,
      MMT_MODE_EDGE   = 1'b1
   } mmt_mode_type;

   // ==========================================================
   // Carriers
   typedef struct packed
   {
      logic         trigger;
      logic         clear_extremes;
      mmt_mode_type trigger_mode_select;
      logic         enable;
   } mmt_ctrl_type;

   typedef struct packed
   {
      logic new_max;
      logic new_min;
   } mmt_event_type;

endpackage : mmt_pkg

// [hdl/mmt_extreme_core.sv]
// Signed minimum and maximum store with clear and new-extreme flags
`timescale 1ns/100ps
`default_nettype none

module mmt_extreme_core
#(
   parameter int unsigned WIDTH = 32
)
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 eval_i,
   input  wire logic                 clear_i,
   input  wire logic [WIDTH-1:0]     sample_i,
   output logic      [WIDTH-1:0]     min_o,
   output logic      [WIDTH-1:0]     max_o,
   output mmt_pkg::mmt_event_type    event_o
);

   // ==========================================================
   // Parameter check
   generate
      if (WIDTH < 2 || WIDTH > mmt_pkg::DATA_W)
      begin : g_bad_width
         $error("mmt_extreme_core: WIDTH must lie in 2..32");
      end
   endgenerate

   // ==========================================================
   // Comparison
   logic [WIDTH-1:0]       min_value;
   logic [WIDTH-1:0]       max_value;
   logic [WIDTH-1:0]       next_min;
   logic [WIDTH-1:0]       next_max;
   mmt_pkg::mmt_event_type next_event;
   mmt_pkg::mmt_event_type event_q;
   wire                    is_lower;
   wire                    is_higher;
   wire                    take_min;
   wire                    take_max;
   wire  [WIDTH-1:0]       zero_value;

   assign zero_value = mmt_pkg::EXTREME_ZERO[WIDTH-1:0];
   assign is_lower   = $signed(sample_i) < $signed(min_value);   // [RL10]
   assign is_higher  = $signed(sample_i) > $signed(max_value);   // [RL10]
   assign take_min   = eval_i && !clear_i && is_lower;           // [RL1] [RL13]
   assign take_max   = eval_i && !clear_i && is_higher;          // [RL1] [RL13]

   // Clear is a level and overrides any evaluation in the same cycle
   assign next_min = clear_i  ? zero_value :                      // [RL5] [RL13]
                     take_min ? sample_i   : min_value;           // [RL2]
   assign next_max = clear_i  ? zero_value :                      // [RL5] [RL13]
                     take_max ? sample_i   : max_value;           // [RL2]
   assign next_event.new_min = take_min;                          // [RL9]
   assign next_event.new_max = take_max;                          // [RL9]

   // ==========================================================
   // Storage: one minimum and one maximum, nothing older
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         min_value <= zero_value;                                 // [RL4]
         max_value <= zero_value;                                 // [RL4]
         event_q   <= '0;
      end
      else
      begin
         min_value <= next_min;                                   // [RL3]
         max_value <= next_max;                                   // [RL3]
         event_q   <= next_event;                                 // [RL9]
      end
   end

   assign min_o   = min_value;
   assign max_o   = max_value;
   assign event_o = event_q;

endmodule : mmt_extreme_core

`default_nettype wire

// [hdl/mmt_min_max_tracker.sv]
// Min/max tracker top: Wishbone registers, evaluation control, interrupt
//
// How it works
// RL1: While enabled, each qualifying evaluation compares the sample with the stored extremes.
// RL2: A sample below the minimum replaces it, and a sample above the maximum replaces it.
// RL3: Exactly one minimum and one maximum are held, with no history of earlier values.
// RL4: Both extremes start at zero when the block comes out of reset.
// RL5: While clear is one, both extremes are forced to zero.
// RL6: In cyclic mode an evaluation happens every cycle and the trigger is ignored.
// RL7: In edge mode an evaluation happens only when the trigger was 0 last cycle and is 1 now.
// RL8: In edge mode software must return the trigger low between requests.
// RL9: Each newly stored extreme raises the event output for exactly one cycle.
// RL10: The sample is compared as a signed 32-bit two's-complement integer.
// RL11: The stored minimum and maximum are shown continuously on their outputs.
// RL12: While disabled and clear is zero, the extremes hold and the event output stays low.
// RL13: Clear beats a coinciding evaluation, leaving zeros and no event.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module mmt_min_max_tracker
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [mmt_pkg::ADDR_W-1:0]   wb_adr_i,
   input  wire logic [mmt_pkg::SEL_W-1:0]    wb_sel_i,
   input  wire logic [mmt_pkg::DATA_W-1:0]   wb_dat_i,
   output logic      [mmt_pkg::DATA_W-1:0]   wb_dat_o,
   output logic                              wb_ack_o,
   output logic      [mmt_pkg::DATA_W-1:0]   min_o,
   output logic      [mmt_pkg::DATA_W-1:0]   max_o,
   output logic                              new_extreme_pulse_o,
   output logic                              irq_o
);

   // ==========================================================
   // Declarations
   localparam int unsigned DW  = mmt_pkg::DATA_W;
   localparam int unsigned SW  = mmt_pkg::SEL_W;
   localparam int unsigned STW = mmt_pkg::STATUS_W;
   localparam int unsigned CTRL_PAD = DW - mmt_pkg::CTRL_W;

   mmt_pkg::mmt_ctrl_type    ctrl;
   mmt_pkg::mmt_ctrl_type    next_ctrl;
   mmt_pkg::mmt_event_type   core_event;

   logic [DW-1:0]            sample_value;
   logic [DW-1:0]            next_sample;
   logic [STW-1:0]           status;
   logic [STW-1:0]           next_status;
   logic [STW-1:0]           mask;
   logic [STW-1:0]           next_mask;
   logic [DW-1:0]            eval_count;
   logic [DW-1:0]            next_eval_count;
   logic                     trigger_prev;
   logic                     ack;
   logic [DW-1:0]            read_data;
   logic [DW-1:0]            core_min;
   logic [DW-1:0]            core_max;

   wire                      bus_req;
   wire                      bus_take;
   wire                      bus_write;
   wire                      hit_ctrl;
   wire                      hit_sample;
   wire                      hit_min;
   wire                      hit_max;
   wire                      hit_status;
   wire                      hit_mask;
   wire                      hit_evals;
   wire                      wr_ctrl;
   wire                      wr_sample;
   wire                      wr_status;
   wire                      wr_mask;
   wire [DW-1:0]             ctrl_word;
   wire [DW-1:0]             status_word;
   wire [DW-1:0]             mask_word;
   wire [DW-1:0]             mux_data;
   wire [CTRL_PAD-1:0]       ctrl_pad;
   wire [DW-STW-1:0]         stat_pad;

   wire                      trigger_rise;
   wire                      cyclic_mode;
   wire                      evaluate;
   wire                      clear_now;
   wire [STW-1:0]            event_bits;
   wire [STW-1:0]            w1c_bits;
   wire                      any_event;

   // ==========================================================
   // Wishbone classic slave
   // The answer is registered so that a write lands on exactly the edge
   // at which the master sees ack; this costs one wait state per access.
   assign bus_req   = wb_cyc_i && wb_stb_i;
   assign bus_take  = bus_req && ack;
   assign bus_write = bus_take && wb_we_i;

   assign hit_ctrl   = (wb_adr_i == mmt_pkg::OFS_CTRL);
   assign hit_sample = (wb_adr_i == mmt_pkg::OFS_SAMPLE);
   assign hit_min    = (wb_adr_i == mmt_pkg::OFS_MIN);
   assign hit_max    = (wb_adr_i == mmt_pkg::OFS_MAX);
   assign hit_status = (wb_adr_i == mmt_pkg::OFS_STATUS);
   assign hit_mask   = (wb_adr_i == mmt_pkg::OFS_MASK);
   assign hit_evals  = (wb_adr_i == mmt_pkg::OFS_EVALS);

   assign wr_ctrl   = bus_write && hit_ctrl   && wb_sel_i[0];
   assign wr_sample = bus_write && hit_sample;
   assign wr_status = bus_write && hit_status && wb_sel_i[0];
   assign wr_mask   = bus_write && hit_mask   && wb_sel_i[0];

   assign ctrl_pad    = '0;
   assign stat_pad    = '0;
   assign ctrl_word   = {ctrl_pad, ctrl};
   assign status_word = {stat_pad, status};
   assign mask_word   = {stat_pad, mask};

   // Unmapped offsets still answer, and read as zero
   assign mux_data = hit_ctrl   ? ctrl_word    :
                     hit_sample ? sample_value :
                     hit_min    ? core_min     :
                     hit_max    ? core_max     :
                     hit_status ? status_word  :
                     hit_mask   ? mask_word    :
                     hit_evals  ? eval_count   : mmt_pkg::DATA_RESET;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack       <= 1'b0;
         read_data <= mmt_pkg::DATA_RESET;
      end
      else
      begin
         ack       <= bus_req && !ack;
         read_data <= mux_data;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = read_data;

   // ==========================================================
   // Control register
   // Trigger is a software-written level; the block looks for its
   // rising edge, so software has to write it back to zero before
   // the next request can be seen.
   assign next_ctrl = wr_ctrl ? mmt_pkg::mmt_ctrl_type'(wb_dat_i[mmt_pkg::CTRL_W-1:0])
                              : ctrl;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl <= mmt_pkg::mmt_ctrl_type'(mmt_pkg::CTRL_RESET);
      end
      else
      begin
         ctrl <= next_ctrl;
      end
   end

   // ==========================================================
   // Sample register, byte lanes honoured
   genvar lane;
   generate
      for (lane = 0; lane < SW; lane++)
      begin : g_sample_lane
         assign next_sample[8*lane +: 8] = (wr_sample && wb_sel_i[lane])
                                           ? wb_dat_i[8*lane +: 8]
                                           : sample_value[8*lane +: 8];
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sample_value <= mmt_pkg::DATA_RESET;
      end
      else
      begin
         sample_value <= next_sample;
      end
   end

   // ==========================================================
   // Evaluation qualifier
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trigger_prev <= 1'b0;
      end
      else
      begin
         trigger_prev <= ctrl.trigger;                             // [RL7]
      end
   end

   assign trigger_rise = ctrl.trigger && !trigger_prev;            // [RL7] [RL8]
   assign cyclic_mode  = (ctrl.trigger_mode_select == mmt_pkg::MMT_MODE_CYCLIC);

   // Cyclic mode never looks at the trigger
   assign evaluate  = ctrl.enable &&                               // [RL1] [RL12]
                      (cyclic_mode || trigger_rise);               // [RL6] [RL7]
   assign clear_now = ctrl.clear_extremes;                         // [RL5]

   // ==========================================================
   // Extreme store
   mmt_extreme_core
   #(
      .WIDTH    (DW)
   )
   u_core
   (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .eval_i   (evaluate),
      .clear_i  (clear_now),
      .sample_i (sample_value),
      .min_o    (core_min),
      .max_o    (core_max),
      .event_o  (core_event)
   );

   assign min_o = core_min;                                        // [RL11]
   assign max_o = core_max;                                        // [RL11]

   // ==========================================================
   // Event output
   // The core flags are registered and recomputed each cycle, so the
   // pulse lasts one cycle per stored extreme.
   assign event_bits = core_event;
   assign any_event  = |event_bits;
   assign new_extreme_pulse_o = any_event;                         // [RL9]

   // ==========================================================
   // Evaluation counter, cleared together with the extremes
   assign next_eval_count = clear_now ? mmt_pkg::DATA_RESET :
                            evaluate  ? DW'(eval_count + mmt_pkg::EVALS_ONE) :
                                        eval_count;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         eval_count <= mmt_pkg::DATA_RESET;
      end
      else
      begin
         eval_count <= next_eval_count;
      end
   end

   // ==========================================================
   // Sticky status, mask and interrupt
   // A new event in the cycle of a write-one-to-clear survives it.
   assign w1c_bits    = wr_status ? wb_dat_i[STW-1:0] : '0;
   assign next_status = (status & ~w1c_bits) | event_bits;
   assign next_mask   = wr_mask ? wb_dat_i[STW-1:0] : mask;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status <= mmt_pkg::STATUS_RESET;
         mask   <= mmt_pkg::MASK_RESET;
      end
      else
      begin
         status <= next_status;
         mask   <= next_mask;
      end
   end

   assign irq_o = |(status & mask);

endmodule : mmt_min_max_tracker

`default_nettype wire

// [bench/mmt_chk.sv]
// Port-level assertion checker for the min/max tracker
`timescale 1ns/100ps
`default_nettype none
module mmt_chk
(
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [mmt_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [mmt_pkg::SEL_W-1:0]  wb_sel_i,
   input wire logic [mmt_pkg::DATA_W-1:0] wb_dat_i,
   input wire logic [mmt_pkg::DATA_W-1:0] wb_dat_o,
   input wire logic                       wb_ack_o,
   input wire logic [mmt_pkg::DATA_W-1:0] min_o,
   input wire logic [mmt_pkg::DATA_W-1:0] max_o,
   input wire logic                       new_extreme_pulse_o,
   input wire logic                       irq_o
);
   // ==========================================================
   // Shadow of the enable and clear bits, taken from completed bus writes
   logic      en_q;
   logic      clr_q;
   wire logic ctrl_wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
                        & (wb_adr_i == mmt_pkg::OFS_CTRL);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_q  <= 1'b0;
         clr_q <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         en_q  <= wb_dat_i[mmt_pkg::CTRL_ENABLE_BIT];
         clr_q <= wb_dat_i[mmt_pkg::CTRL_CLEAR_BIT];
      end
   end
   default clocking mmt_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Properties
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack did not follow a request");
   pulse_single_a: assert property (new_extreme_pulse_o |=> !new_extreme_pulse_o)
      else $error("event pulse longer than one cycle");
   pulse_cause_a: assert property (new_extreme_pulse_o |->
      $changed(min_o) || $changed(max_o))
      else $error("event pulse without a stored extreme");
   change_pulse_a: assert property (($changed(min_o) && min_o != mmt_pkg::EXTREME_ZERO)
      || ($changed(max_o) && max_o != mmt_pkg::EXTREME_ZERO) |-> new_extreme_pulse_o)
      else $error("extreme stored without event pulse");
   sign_bound_a: assert property ($signed(min_o) <= 0 && $signed(max_o) >= 0)
      else $error("extremes moved across their zero start");
   min_down_a: assert property ($changed(min_o) |->
      $signed(min_o) < $signed($past(min_o)) || min_o == mmt_pkg::EXTREME_ZERO)
      else $error("minimum rose without clear");
   max_up_a: assert property ($changed(max_o) |->
      $signed(max_o) > $signed($past(max_o)) || max_o == mmt_pkg::EXTREME_ZERO)
      else $error("maximum fell without clear");
   clear_zero_a: assert property (clr_q |=>
      min_o == '0 && max_o == '0 && !new_extreme_pulse_o)
      else $error("clear did not zero the extremes");
   hold_off_a: assert property (!en_q && !clr_q |=>
      $stable(min_o) && $stable(max_o) && !new_extreme_pulse_o)
      else $error("extremes changed while disabled");
   read_min_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == mmt_pkg::OFS_MIN
      |-> wb_dat_o == $past(min_o))
      else $error("bus read of minimum differs from output");
   read_max_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == mmt_pkg::OFS_MAX
      |-> wb_dat_o == $past(max_o))
      else $error("bus read of maximum differs from output");
endmodule : mmt_chk
bind mmt_min_max_tracker mmt_chk mmt_chk_inst
(
   .clk_i               (clk_i),
   .rst_i               (rst_i),
   .wb_cyc_i            (wb_cyc_i),
   .wb_stb_i            (wb_stb_i),
   .wb_we_i             (wb_we_i),
   .wb_adr_i            (wb_adr_i),
   .wb_sel_i            (wb_sel_i),
   .wb_dat_i            (wb_dat_i),
   .wb_dat_o            (wb_dat_o),
   .wb_ack_o            (wb_ack_o),
   .min_o               (min_o),
   .max_o               (max_o),
   .new_extreme_pulse_o (new_extreme_pulse_o),
   .irq_o               (irq_o)
);
`default_nettype wire

// [bench/mmt_sw_model.sv]
// Bus master standing in for the controller program that drives the tracker
`timescale 1ns/100ps
`default_nettype none
module mmt_sw_model
(
   input  wire logic                       clk_i,
   input  wire logic                       ack_i,
   input  wire logic [mmt_pkg::DATA_W-1:0] dat_i,
   output logic                            cyc_o,
   output logic                            stb_o,
   output logic                            we_o,
   output logic      [mmt_pkg::ADDR_W-1:0] adr_o,
   output logic      [mmt_pkg::SEL_W-1:0]  sel_o,
   output logic      [mmt_pkg::DATA_W-1:0] dat_o
);
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hf;
      dat_o = 32'h0;
   end
   // One classic access; idle address and data are inverted so stale values never look valid
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic late);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      dat_o <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_i !== 1'b1 && n < 20);
      q = dat_i;
      late = (ack_i !== 1'b1);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask : access
endmodule : mmt_sw_model
`default_nettype wire

// [bench/mmt_min_max_tracker_tb_top.sv]
// Self-checking bench for the min/max tracker
`timescale 1ns/100ps
`default_nettype none
module mmt_min_max_tracker_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, pulse, irq;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, wb_rdat, rdat, min_v, max_v;
   logic [31:0] x = 32'h28a2;
   logic [1:0]  st_r = 2'h0;
   int          error_cnt = 0;
   int          check_count = 0;
   int          min_r = 0, max_r = 0, sreg = 0, ctl = 0;
   always #50 clk_i = ~clk_i;
   mmt_min_max_tracker mmt_min_max_tracker_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_rdat), .wb_ack_o(ack), .min_o(min_v), .max_o(max_v),
      .new_extreme_pulse_o(pulse), .irq_o(irq));
   mmt_sw_model mmt_sw_model_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(wb_rdat), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // ==========================================================
   // Checking and reference model
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      next_rand = v ^ (v << 5);
   endfunction : next_rand
   function automatic logic eval();
      eval = 1'b0;
      if (sreg < min_r)
      begin
         min_r = sreg;
         st_r[0] = 1'b1;
         eval = 1'b1;
      end
      if (sreg > max_r)
      begin
         max_r = sreg;
         st_r[1] = 1'b1;
         eval = 1'b1;
      end
   endfunction : eval
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic late;
      mmt_sw_model_inst.access(w, a, d, rdat, late);
      if (late)
      begin
         error_cnt++;
         test_done();
      end
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, rdat, e);
   endtask : rd
   // Compare in the cycle after a write lands, when its evaluation shows
   task automatic step(input logic rise);
      logic nw;
      nw = 1'b0;
      @(posedge clk_i);
      #1;
      if (ctl[2])
      begin
         min_r = 0;
         max_r = 0;
      end
      else if (ctl[0] && (!ctl[1] || rise))
         nw = eval();
      chk("pulse", {31'h0, pulse}, {31'h0, nw});
      chk("min", min_v, min_r);
      chk("max", max_v, max_r);
   endtask : step
   task automatic setctl(input int v);
      logic rise;
      rise = v[3] && !ctl[3];
      bus(1'b1, mmt_pkg::OFS_CTRL, v);
      ctl = v;
      step(rise);
   endtask : setctl
   task automatic put(input int s);
      bus(1'b1, mmt_pkg::OFS_SAMPLE, s);
      sreg = s;
      step(1'b0);
   endtask : put
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 32; a += 4)
         rd(a[7:0], 32'h0, "reset read");
      put(-7);
      bus(1'b1, mmt_pkg::OFS_MASK, 32'h1);
      setctl(1);
      for (int i = 0; i < 14; i++)
      begin
         x = next_rand(x);
         put(i == 11 ? 32'h8000_0000 : i > 11 ? 32'h7fff_ffff : x);
      end
      rd(mmt_pkg::OFS_STATUS, {30'h0, st_r}, "status");
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b1, mmt_pkg::OFS_MIN, 32'h5);
      rd(mmt_pkg::OFS_MIN, min_r, "min read");
      rd(mmt_pkg::OFS_MAX, max_r, "max read");
      bus(1'b1, mmt_pkg::OFS_STATUS, 32'h3);
      st_r = 2'h0;
      rd(mmt_pkg::OFS_STATUS, 32'h0, "status cleared");
      chk("irq cleared", {31'h0, irq}, 32'h0);
      setctl(5);
      setctl(1);
      rd(mmt_pkg::OFS_STATUS, {30'h0, st_r}, "status max");
      chk("irq masked", {31'h0, irq}, 32'h0);
      setctl(3);
      put(-20);
      setctl(11);
      put(-30);
      setctl(11);
      setctl(3); // trigger returned low between requests
      setctl(11);
      setctl(7);
      setctl(15);
      setctl(0);
      setctl(8);
      setctl(1);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("min after reset", min_v, 32'h0);
      test_done();
   end
endmodule : mmt_min_max_tracker_tb_top
`default_nettype wire
